// ### core/cad_pkg.sv
// Constants, types and carriers shared by the address, carry and I/O decode core.
package cad_pkg;
  localparam int WORD_W = 16;
  localparam int MEMW_W = 17;
  localparam int ADDR_W = 13;
  localparam int PC_W   = 15;
  localparam int UNIT_W = 6;
  localparam int AXI_AW = 5;

  localparam logic [3:0] OP_AUG = 4'h0;
  localparam logic [3:0] OP_LDA = 4'h1;
  localparam logic [3:0] OP_LDB = 4'h2;
  localparam logic [3:0] OP_STA = 4'h3;
  localparam logic [3:0] OP_STB = 4'h4;
  localparam logic [3:0] OP_ADD = 4'h5;
  localparam logic [3:0] OP_SUB = 4'h6;
  localparam logic [3:0] OP_BRU = 4'h7;
  localparam logic [3:0] OP_IO2 = 4'hb;
  localparam logic [3:0] OP_IO1 = 4'hf;
  localparam logic [5:0] AUG_CSB = 6'h01;

  localparam int POS_X  = 11;
  localparam int POS_R  = 11;
  localparam int POS_I  = 10;
  localparam int POS_M  = 9;
  localparam int POS_W  = 4;
  localparam int AUG_HI = 6;
  localparam int AUG_LO = 4;

  localparam logic [1:0] K2_CMD  = 2'h0;
  localparam logic [1:0] K2_TEST = 2'h1;
  localparam logic [1:0] K2_MOUT = 2'h2;
  localparam logic [1:0] K2_MIN  = 2'h3;

  localparam logic [3:0] SETTLE_CYC = 4'h2;

  localparam logic [AXI_AW-1:0] RA_CTRL  = 5'h00;
  localparam logic [AXI_AW-1:0] RA_STAT  = 5'h04;
  localparam logic [AXI_AW-1:0] RA_PC    = 5'h08;
  localparam logic [AXI_AW-1:0] RA_ACCA  = 5'h0c;
  localparam logic [AXI_AW-1:0] RA_ACCB  = 5'h10;
  localparam logic [AXI_AW-1:0] RA_IDX   = 5'h14;
  localparam logic [AXI_AW-1:0] RA_INSTR = 5'h18;
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_XSEL = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [9:0] {
    S_IDLE   = 10'h001,
    S_FETCH  = 10'h002,
    S_DECODE = 10'h004,
    S_WORD2  = 10'h008,
    S_OPRD   = 10'h010,
    S_EXEC   = 10'h020,
    S_STORE  = 10'h040,
    S_IOTEST = 10'h080,
    S_IOXFER = 10'h100,
    S_DONE   = 10'h200
  } cad_state_t;

  typedef enum logic [2:0] {
    IOK_NONE = 3'h0,
    IOK_CMD  = 3'h1,
    IOK_TEST = 3'h2,
    IOK_MOUT = 3'h3,
    IOK_MIN  = 3'h4,
    IOK_AOUT = 3'h5,
    IOK_AIN  = 3'h6
  } cad_iok_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [1:0]        module_sel;
    logic [ADDR_W-1:0] addr;
    logic [MEMW_W-1:0] wdata;
  } cad_mem_t;

  typedef struct packed {
    logic              connect;
    logic              xfer;
    cad_iok_t          kind;
    logic [UNIT_W-1:0] unit;
    logic [WORD_W-1:0] dout;
  } cad_io_t;
endpackage

// ### core/cad_core.sv
// Processor slice: carry latch, fetch, address formation, store parity and I/O instruction sequencing.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cad_core (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [cad_pkg::AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output wire logic                          s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output wire logic                          s_axi_wready,
  output wire logic [1:0]                    s_axi_bresp,
  output wire logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [cad_pkg::AXI_AW-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output wire logic                          s_axi_arready,
  output wire logic [31:0]                   s_axi_rdata,
  output wire logic [1:0]                    s_axi_rresp,
  output wire logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output wire cad_pkg::cad_mem_t             mem_o,
  input  wire logic                          mem_ack,
  input  wire logic [cad_pkg::MEMW_W-1:0]    mem_rdata,
  output wire cad_pkg::cad_io_t              io_o,
  input  wire logic                          io_ready,
  input  wire logic                          io_test_return,
  input  wire logic [cad_pkg::WORD_W-1:0]    io_din
);
  import cad_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cad_state_t        state_reg;
  logic [PC_W-1:0]   pc_reg;
  logic [PC_W-1:0]   ea_reg;
  logic [WORD_W-1:0] ir_reg;
  logic [WORD_W-1:0] t_reg;
  logic [WORD_W-1:0] a_reg;
  logic [WORD_W-1:0] b_reg;
  logic [WORD_W-1:0] x_reg;
  logic              carry_reg;
  logic [1:0]        step_reg;
  logic [3:0]        settle_reg;
  logic [1:0]        ctrl_reg;
  cad_mem_t          mem_reg;
  cad_io_t           io_reg;
  logic [17:0]       sy1_reg;
  logic [17:0]       sy2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave.
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic              aw_hold_reg;
  logic              w_hold_reg;
  logic [AXI_AW-1:0] waddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;

  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  wire aw_take = s_axi_awvalid && awready_reg;
  wire w_take  = s_axi_wvalid && wready_reg;
  wire wr_do   = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire aw_hold_next = (aw_hold_reg || aw_take) && !wr_do;
  wire w_hold_next  = (w_hold_reg || w_take) && !wr_do;
  wire wr_hit = waddr_reg inside {RA_CTRL, RA_PC, RA_ACCA, RA_ACCB, RA_IDX, RA_STAT, RA_INSTR};
  wire ar_take = s_axi_arvalid && arready_reg;
  wire rvalid_next = (rvalid_reg && !s_axi_rready) || ar_take;
  wire running = state_reg != S_IDLE;
  // Datapath registers only accept software writes while the core is stopped.
  wire sw_ok = wr_do && !running;
  wire [15:0] pc_wr = wmerge({1'b0, pc_reg}, wdata_reg, wstrb_reg);
  wire ar_hit = s_axi_araddr inside {RA_CTRL, RA_STAT, RA_PC, RA_ACCA, RA_ACCB, RA_IDX, RA_INSTR};
  wire [31:0] rd_word =
    (s_axi_araddr == RA_CTRL)  ? {30'h0, ctrl_reg} :
    (s_axi_araddr == RA_STAT)  ? {29'h0, carry_reg, io_reg.connect, running} :
    (s_axi_araddr == RA_PC)    ? {17'h0, pc_reg} :
    (s_axi_araddr == RA_ACCA)  ? {16'h0, a_reg} :
    (s_axi_araddr == RA_ACCB)  ? {16'h0, b_reg} :
    (s_axi_araddr == RA_IDX)   ? {16'h0, x_reg} :
    (s_axi_araddr == RA_INSTR) ? {16'h0, ir_reg} : 32'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      waddr_reg   <= '0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0;
      ctrl_reg    <= CTRL_RST;
    end
    else
    begin
      awready_reg <= !aw_hold_next;
      wready_reg  <= !w_hold_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      if (aw_take)
        waddr_reg <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
      if (wr_do && waddr_reg == RA_CTRL && wstrb_reg[0])
        ctrl_reg <= wdata_reg[1:0];
      arready_reg <= !rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_take)
      begin
        rdata_reg <= rd_word;
        rresp_reg <= ar_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode and adder.
  wire [3:0] opc    = ir_reg[15:12];
  wire is_io2       = opc == OP_IO2;
  wire is_io1       = opc == OP_IO1;
  wire is_io        = is_io2 || is_io1;
  wire is_csb       = opc == OP_AUG && ir_reg[5:0] == AUG_CSB;
  wire is_sub       = opc == OP_SUB;
  wire is_add       = opc == OP_ADD;
  wire is_st        = opc == OP_STA || opc == OP_STB;
  wire [1:0] aug    = ir_reg[AUG_HI:AUG_LO+1];
  wire f_ind        = ir_reg[POS_I];
  wire f_map        = ir_reg[POS_M];
  wire f_idx        = ir_reg[POS_X];
  wire f_merge      = ir_reg[POS_R];
  wire [UNIT_W-1:0] unit = {ir_reg[8:7], ir_reg[3:0]};
  cad_iok_t iok;
  assign iok = is_io2 ? (aug == K2_CMD  ? IOK_CMD  :
                         aug == K2_TEST ? IOK_TEST :
                         aug == K2_MOUT ? IOK_MOUT : IOK_MIN) :
               is_io1 ? (aug[1] ? IOK_AIN : IOK_AOUT) : IOK_NONE;
  wire f_wait  = ir_reg[POS_W] && iok != IOK_TEST;
  wire need_rd = f_ind && iok != IOK_MIN;

  wire in_dec = state_reg == S_DECODE;
  wire [15:0] ea_base = {7'h00, ir_reg[8:0]} |
                        (f_map ? {1'b0, pc_reg[14:9], 9'h000} : 16'h0000);
  wire [15:0] idx_src = ctrl_reg[CTRL_XSEL] ? x_reg : b_reg;
  wire [15:0] add_a = in_dec ? ea_base :
                      (is_add || is_sub || opc == OP_STA) ? a_reg :
                      (opc == OP_STB) ? b_reg : 16'h0000;
  wire [15:0] add_b = in_dec ? (f_idx ? idx_src : 16'h0000) :
                      is_sub ? ~t_reg : is_st ? 16'h0000 : t_reg;
  // Subtract sees the inverted latch, so a cleared latch gives the usual plus one.
  wire add_c = !in_dec && (is_sub ? !carry_reg : (is_add && carry_reg));
  wire [15:0] sum = add_a + add_b + {15'h0000, add_c};
  wire parity = ~^sum;

  wire [PC_W-1:0] pc_plus1 = pc_reg + 15'h0001;
  wire [PC_W-1:0] maddr = (state_reg == S_FETCH) ? pc_reg :
                          (state_reg == S_WORD2) ? pc_plus1 : ea_reg;
  wire in_mem = state_reg inside {S_FETCH, S_WORD2, S_OPRD, S_STORE};

  // Device pins are asynchronous to this clock.
  wire rdy_s = sy2_reg[17];
  wire ret_s = sy2_reg[16];
  wire [15:0] din_s = sy2_reg[15:0];
  wire io_go = state_reg == S_IOTEST && settle_reg == 4'h0 && (iok == IOK_TEST || rdy_s);
  wire io_start = (in_dec && is_io1) ||
                  (state_reg == S_WORD2 && mem_ack && !need_rd) ||
                  (state_reg == S_OPRD && mem_ack && is_io);
  wire test_skip = iok == IOK_TEST && ret_s;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and datapath.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= S_IDLE;
      pc_reg    <= PC_RST;
      carry_reg <= 1'b0;
      ea_reg    <= '0;
      ir_reg    <= 16'h0000;
      t_reg     <= 16'h0000;
      a_reg     <= 16'h0000;
      b_reg     <= 16'h0000;
      x_reg     <= 16'h0000;
      step_reg  <= 2'h0;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          if (sw_ok && waddr_reg == RA_PC)
            pc_reg <= pc_wr[14:0];
          if (sw_ok && waddr_reg == RA_ACCA)
            a_reg <= wmerge(a_reg, wdata_reg, wstrb_reg);
          if (sw_ok && waddr_reg == RA_ACCB)
            b_reg <= wmerge(b_reg, wdata_reg, wstrb_reg);
          if (sw_ok && waddr_reg == RA_IDX)
            x_reg <= wmerge(x_reg, wdata_reg, wstrb_reg);
          if (ctrl_reg[CTRL_RUN])
            state_reg <= S_FETCH;
        end
        S_FETCH:
          if (mem_ack)
          begin
            ir_reg    <= mem_rdata[15:0];
            t_reg     <= mem_rdata[15:0];
            state_reg <= S_DECODE;
          end
        S_DECODE:
        begin
          step_reg <= is_io2 ? 2'h2 : (opc == OP_BRU ? 2'h0 : 2'h1);
          if (is_io2)
            state_reg <= S_WORD2;
          else if (is_io1)
            state_reg <= S_IOTEST;
          else if (opc == OP_BRU)
          begin
            pc_reg    <= sum[14:0];
            state_reg <= S_DONE;
          end
          else if (opc inside {OP_LDA, OP_LDB, OP_ADD, OP_SUB})
          begin
            ea_reg    <= sum[14:0];
            state_reg <= S_OPRD;
          end
          else if (is_st)
          begin
            ea_reg    <= sum[14:0];
            state_reg <= S_STORE;
          end
          else
          begin
            if (is_csb)
            begin
              carry_reg  <= b_reg[15];
              b_reg[15]  <= 1'b0;
            end
            state_reg <= S_DONE;
          end
        end
        S_WORD2:
          if (mem_ack)
          begin
            t_reg     <= mem_rdata[15:0];
            ea_reg    <= f_ind ? mem_rdata[14:0] : pc_plus1;
            state_reg <= need_rd ? S_OPRD : S_IOTEST;
          end
        S_OPRD:
          if (mem_ack)
          begin
            t_reg     <= mem_rdata[15:0];
            state_reg <= is_io ? S_IOTEST : S_EXEC;
          end
        S_EXEC:
        begin
          if (opc == OP_LDB)
            b_reg <= sum;
          else
            a_reg <= sum;
          state_reg <= S_DONE;
        end
        S_STORE:
          if (mem_ack)
            state_reg <= S_DONE;
        S_IOTEST:
          // The counter stays put while waiting for the device.
          if (io_go)
            state_reg <= S_IOXFER;
          else if (settle_reg == 4'h0 && !f_wait)
            state_reg <= S_DONE;
        S_IOXFER:
        begin
          if (iok == IOK_AIN)
            a_reg <= f_merge ? (a_reg | din_s) : din_s;
          if (iok == IOK_MIN)
            t_reg <= din_s;
          if (!f_wait && iok != IOK_TEST)
            step_reg <= step_reg + 2'h1;
          state_reg <= (iok == IOK_MIN) ? S_STORE : S_DONE;
        end
        S_DONE:
        begin
          pc_reg <= pc_reg + {13'h0000, step_reg} + {14'h0000, test_skip};
          if (!is_csb)
            carry_reg <= 1'b0;
          state_reg <= ctrl_reg[CTRL_RUN] ? S_FETCH : S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory port and I/O bus.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mem_reg <= '0;
    else
    begin
      mem_reg.req        <= in_mem && !mem_ack;
      mem_reg.we         <= state_reg == S_STORE;
      mem_reg.addr       <= maddr[ADDR_W-1:0];
      mem_reg.module_sel <= maddr[ADDR_W-1:ADDR_W-2];
      mem_reg.wdata      <= {parity, sum};
    end
  end
  assign mem_o = mem_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sy1_reg <= 18'h00000;
      sy2_reg <= 18'h00000;
    end
    else
    begin
      sy1_reg <= {io_ready, io_test_return, io_din};
      sy2_reg <= sy1_reg;
    end
  end

  // A fixed settle gives the device answer time to pass the synchroniser.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      io_reg     <= '0;
      settle_reg <= 4'h0;
    end
    else
    begin
      io_reg.xfer <= io_go;
      if (io_go)
        io_reg.dout <= (iok == IOK_AOUT) ? a_reg : t_reg;
      if (io_start)
      begin
        io_reg.connect <= 1'b1;
        io_reg.unit    <= unit;
        io_reg.kind    <= iok;
        settle_reg     <= SETTLE_CYC;
      end
      else if (state_reg == S_DONE)
        io_reg.connect <= 1'b0;
      else if (settle_reg != 4'h0)
        settle_reg <= settle_reg - 4'h1;
    end
  end
  assign io_o = io_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_carry_clear: assert property (state_reg == S_DONE && !is_csb |=> !carry_reg)
    else $error("carry latch kept after instruction end");
  a_csb_copy: assert property (in_dec && is_csb |=> carry_reg == $past(b_reg[15]) && !b_reg[15])
    else $error("copy-B-sign did not move the sign");
  a_sub_cin: assert property (state_reg == S_EXEC && is_sub |-> add_c == !carry_reg)
    else $error("subtract carry-in not inverted latch");
  a_pc_step: assert property (state_reg == S_DONE && opc == OP_LDA |=> pc_reg == $past(pc_reg) + 15'h0001)
    else $error("counter did not advance by one");
  a_wait_hold: assert property (state_reg == S_IOTEST && f_wait && !io_go |=>
    state_reg == S_IOTEST && $stable(pc_reg))
    else $error("wait mode left test or moved counter");
  a_skip_two: assert property (state_reg == S_IOXFER && is_io1 && !f_wait ##1 state_reg == S_DONE
    |=> pc_reg == $past(pc_reg, 2) + 15'h0002)
    else $error("skip mode did not advance by two");
  a_xfer_conn: assert property (io_reg.xfer |-> io_reg.connect ##1 !io_reg.xfer)
    else $error("transfer without connection");
  a_io_group: assert property (in_dec && (opc == OP_IO1 || opc == OP_IO2) |=>
    state_reg inside {S_IOTEST, S_WORD2})
    else $error("I/O code not steered to I/O sequence");
  a_store_par: assert property (mem_reg.req && mem_reg.we |-> ^mem_reg.wdata)
    else $error("stored word parity not odd");
  // The reset check must not be switched off by the very reset that it watches.
  a_reset_clr: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> pc_reg == PC_RST && !carry_reg && !io_reg.connect)
    else $error("reset did not clear counter, carry or bus");
endmodule

// ### bench/cad_partner.sv
// Memory module and peripheral controller model facing the core.
`timescale 1ns/1ps
module cad_partner (
  input  wire  logic                       aclk,
  input  wire  cad_pkg::cad_mem_t          mem_o,
  output logic                             mem_ack,
  output logic [cad_pkg::MEMW_W-1:0]       mem_rdata,
  input  wire  cad_pkg::cad_io_t           io_o,
  output logic                             io_ready,
  output logic                             io_test_return,
  output logic [cad_pkg::WORD_W-1:0]       io_din
);
  import cad_pkg::*;
  logic [MEMW_W-1:0] mem [0:8191];
  logic [3:0]        lat;
  logic [3:0]        io_cnt;
  logic              slow;
  initial
  begin
    {mem_ack, mem_rdata, io_ready, io_test_return, io_din, lat, io_cnt, slow} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Answers alternate fast and slow; idle data lines toggle so stale values never pass.
  always @(posedge aclk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_o.req && !mem_ack)
    begin
      lat <= lat + 4'h1;
      if (lat == (slow ? 4'h2 : 4'h0))
      begin
        mem_ack <= 1'b1;
        slow <= ~slow;
        lat <= 4'h0;
        if (mem_o.we) mem[mem_o.addr] <= mem_o.wdata;
        else mem_rdata <= mem[mem_o.addr];
      end
    end
    io_cnt <= io_o.connect ? io_cnt + {3'h0, io_cnt != 4'hf} : 4'h0;
    io_ready <= io_o.connect && io_cnt >= 4'h4;
    io_din <= io_o.connect ? 16'h5a5a : ~io_din;
  end
endmodule

// ### bench/cpu_address_carry_io_decode_tb_top.sv
// Testbench: runs two short programs and checks registers, stored parity and I/O output.
`timescale 1ns/1ps
module cpu_address_carry_io_decode_tb_top;
  import cad_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic mem_ack, io_ready, io_test_return;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire cad_mem_t mem_o;
  wire cad_io_t io_o;
  wire logic [MEMW_W-1:0] mem_rdata;
  wire logic [WORD_W-1:0] io_din;
  logic [33:0] rd_q[$];
  logic [15:0] io_q[$], da, db, sum, b2;
  int n_fail = 0, comparisons = 0, seed = 73, i;
  always #4 aclk = ~aclk;
  cad_core uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_o, .mem_ack, .mem_rdata,
    .io_o, .io_ready, .io_test_return, .io_din);
  cad_partner u_part (.aclk, .mem_o, .mem_ack, .mem_rdata, .io_o, .io_ready, .io_test_return, .io_din);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    comparisons++;
    if (g !== e)
    begin
      $display("Error %0t: got %h expected %h", $time, g, e);
      n_fail++;
    end
  endtask
  // One bus cycle; the expected response is queued before the request goes out.
  task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] d, input logic [33:0] e);
    bit aw, w, b, ar, r;
    rd_q.push_back(e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    repeat (200)
    begin
      @(negedge aclk);
      if (!(s_axi_awvalid | s_axi_wvalid | s_axi_bready | s_axi_arvalid | s_axi_rready)) break;
      {aw, w, b} = {s_axi_awready & s_axi_awvalid, s_axi_wready & s_axi_wvalid, s_axi_bvalid};
      {ar, r} = {s_axi_arready & s_axi_arvalid, s_axi_rvalid};
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
      if (b) s_axi_bready <= 0;
      if (ar) s_axi_arvalid <= 0;
      if (r) s_axi_rready <= 0;
    end
    if (s_axi_bready | s_axi_rready)
    begin
      cmp(34'h0, 34'h1);
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Results are checked in arrival order against the queued notes.
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp({s_axi_bresp, 32'h0}, rd_q.pop_front());
    if (io_o.xfer) cmp({9'h0, io_o.kind, io_o.unit, io_o.dout}, {9'h0, IOK_AOUT, 6'h05, io_q.pop_front()});
    if (io_o.xfer) cmp({33'h0, io_o.connect}, 34'h1);
    if (mem_o.req) cmp({32'h0, mem_o.module_sel}, {32'h0, mem_o.addr[12:11]});
  end
  initial
  begin
    da = $random(seed);
    db = $random(seed);
    sum = da + db;
    u_part.mem[0] = 17'h01020;
    u_part.mem[1] = 17'h05021;
    u_part.mem[2] = 17'h03022;
    u_part.mem[3] = 17'h0f015;
    u_part.mem[4] = 17'h07004;
    u_part.mem[8] = 17'h00001;
    u_part.mem[9] = 17'h06021;
    u_part.mem[10] = 17'h0f005;
    u_part.mem[11] = 17'h0700b;
    u_part.mem[32] = {~^da, da};
    u_part.mem[33] = {~^db, db};
    io_q.push_back(sum);
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    bus(0, RA_PC, 0, {RESP_OKAY, 32'h0});
    bus(0, RA_STAT, 0, {RESP_OKAY, 32'h0});
    bus(0, 5'h1c, 0, {RESP_SLVERR, 32'h0});
    bus(1, RA_CTRL, 1, {RESP_OKAY, 32'h0});
    // The program ends in a branch to itself, so stopping lands on a known counter.
    for (i = 0; i < 400 && io_q.size() != 0; i++) @(posedge aclk);
    bus(1, RA_CTRL, 0, {RESP_OKAY, 32'h0});
    bus(0, RA_ACCA, 0, {RESP_OKAY, 16'h0, sum});
    bus(0, RA_PC, 0, {RESP_OKAY, 32'h4});
    cmp({17'h0, u_part.mem[34]}, {17'h0, ~^sum, sum});
    cmp({33'h0, io_q.size() != 0}, 34'h0);
    // Second run: a borrow moved through the carry latch, then a skip-mode output that no device answers.
    b2 = $random(seed);
    repeat (20) @(posedge aclk);
    bus(0, RA_STAT, 0, {RESP_OKAY, 32'h0});
    bus(1, RA_ACCB, {16'h0, b2}, {RESP_OKAY, 32'h0});
    bus(1, RA_PC, 32'h8, {RESP_OKAY, 32'h0});
    bus(1, RA_CTRL, 1, {RESP_OKAY, 32'h0});
    repeat (100) @(posedge aclk);
    bus(1, RA_CTRL, 0, {RESP_OKAY, 32'h0});
    repeat (20) @(posedge aclk);
    bus(0, RA_ACCA, 0, {RESP_OKAY, 16'h0, sum - db - {15'h0, b2[15]}});
    bus(0, RA_ACCB, 0, {RESP_OKAY, 17'h0, b2[14:0]});
    bus(0, RA_PC, 0, {RESP_OKAY, 32'hb});
    bus(0, RA_STAT, 0, {RESP_OKAY, 32'h0});
    summarize();
  end
endmodule
